// ---- hdl/ppc_port.v ----
// One 8-bit port: config bits, synchroniser, per-bit decode.
// Assumes pin levels arrive asynchronously; peripherals are on i_sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"
module ppc_port #(
    parameter W = `PPC_WIDTH,
    parameter [7:0] SCHMITT_MASK = 8'hf3,
    parameter [7:0] PULLUP_MASK = 8'hf3,
    parameter [7:0] PURE_OD_MASK = 8'h0c,
    parameter [7:0] MEM_MASK = 8'h00
) (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire [W-1:0] i_cfg_lvl,
    input wire [W-1:0] i_cfg_one,
    input wire [W-1:0] i_cfg_zero,
    input wire [W-1:0] i_gpio_out,
    input wire [W-1:0] i_pf_out,
    input wire i_mem_en,
    input wire [W-1:0] i_mem_out,
    input wire [W-1:0] i_mem_oe,
    input wire [W-1:0] i_pin,
    output reg [W-1:0] o_pin_out,
    output reg [W-1:0] o_pin_oe,
    output reg [W-1:0] o_pullup,
    output reg [W-1:0] o_schmitt,
    output reg [W-1:0] o_ttl,
    output reg [W-1:0] o_ain_sel,
    output reg [W-1:0] o_pin_in,
    output reg [W-1:0] o_pf_in
);
    reg [W-1:0] sync1_r;
    reg [W-1:0] sync2_r;
    wire [W-1:0] dl;
    wire [W-1:0] dh;
    wire [W-1:0] pu;
    wire [W-1:0] st;
    wire [W-1:0] tt;
    wire [W-1:0] ps;
    wire [W-1:0] an;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : bits
            ppc_bit #(
                .HAS_SCHMITT(SCHMITT_MASK[g]),
                .HAS_PULLUP(PULLUP_MASK[g]),
                .PURE_OD(PURE_OD_MASK[g])
            ) u_bit (
                .i_lvl(i_cfg_lvl[g]),
                .i_c1(i_cfg_one[g]),
                .i_c0(i_cfg_zero[g]),
                .i_gpio_out(i_gpio_out[g]),
                .i_pf_out(i_pf_out[g]),
                .i_mem_en(i_mem_en & MEM_MASK[g]),
                .i_mem_out(i_mem_out[g]),
                .i_mem_oe(i_mem_oe[g]),
                .o_drive_low(dl[g]),
                .o_drive_high(dh[g]),
                .o_pullup(pu[g]),
                .o_schmitt(st[g]),
                .o_ttl(tt[g]),
                .o_pf_sel(ps[g]),
                .o_ain_sel(an[g])
            );
        end
    endgenerate
    always @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_r <= {W{1'b0}};
            sync2_r <= {W{1'b0}};
            o_pin_out <= {W{1'b0}};
            o_pin_oe <= {W{1'b0}};
            o_pullup <= {W{1'b0}};
            o_schmitt <= {W{1'b0}};
            o_ttl <= {W{1'b0}};
            o_ain_sel <= {W{1'b0}};
            o_pin_in <= {W{1'b0}};
            o_pf_in <= {W{1'b0}};
        end
        else if (i_ce)
        begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
            // Open drain: drive only the low level, high left to the wire
            o_pin_out <= dh;
            o_pin_oe <= dl | dh;
            o_pullup <= pu;
            o_schmitt <= st;
            o_ttl <= tt;
            o_ain_sel <= an;
            o_pin_in <= sync2_r;
            // Peripheral inputs see the pin always; no selection needed
            o_pf_in <= sync2_r;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/ppc_defines.vh ----
// Constants for the port pin configuration block.
// Assumes it is included by bare name from the design files.
// What this block does
// - Each port bit is configured on its own as input or input/output.
// - Bits without a Schmitt stage use TTL or CMOS threshold from their level select bit.
// - Bits with a Schmitt stage ignore the level select bit and stay Schmitt.
// - At most one peripheral function drives a pin at a time.
// - A peripheral input reaches its pin just because the peripheral is enabled.
// - Open-drain mode only disables the high-side driver; low is still driven.
// - Pure open-drain bits have no push-pull option and no weak pull-up.
// - Interrupt-capable inputs always pass a Schmitt stage.
// - The memory-interface bits carry external memory signals when that is on.
// - Only bits built with a weak pull-up ever apply one.
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH
`define PPC_WIDTH 8
`define PPC_SYNC_RST 2'h0
`define PPC_CFG_RST 3'h1
`endif

// ---- hdl/ppc_bit.v ----
// One port bit: decodes three config bits into drivers, pull-up and input stage.
// Assumes pin input already synchronised by the parent.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"
module ppc_bit #(
    parameter HAS_SCHMITT = 1'b1,
    parameter HAS_PULLUP = 1'b1,
    parameter PURE_OD = 1'b0
) (
    input wire i_lvl,
    input wire i_c1,
    input wire i_c0,
    input wire i_gpio_out,
    input wire i_pf_out,
    input wire i_mem_en,
    input wire i_mem_out,
    input wire i_mem_oe,
    output wire o_drive_low,
    output wire o_drive_high,
    output wire o_pullup,
    output wire o_schmitt,
    output wire o_ttl,
    output wire o_pf_sel,
    output wire o_ain_sel
);
    wire out_mode;
    wire od_mode;
    wire level;
    wire en;
    // Code lvl,c1,c0: 001/011 push-pull out, 110 open-drain out, 101/111/x00/010 input
    // Schmitt function input 101 must never drive, or it fights the far end
    assign out_mode = (i_c0 & ~i_lvl) | (i_c1 & ~i_c0 & i_lvl);
    assign o_pf_sel = i_c1 & i_c0 & ~i_lvl & ~i_mem_en;
    assign o_ain_sel = i_c1 & ~i_c0 & ~i_lvl & ~i_mem_en;
    assign od_mode = (i_c1 & ~i_c0 & i_lvl) | PURE_OD;
    assign en = i_mem_en ? i_mem_oe : out_mode;
    assign level = i_mem_en ? i_mem_out : (o_pf_sel ? i_pf_out : i_gpio_out);
    assign o_drive_low = en & ~level;
    assign o_drive_high = en & level & ~od_mode;
    assign o_pullup = HAS_PULLUP & ~PURE_OD & ~en & ~i_c0 & ~i_c1 & ~i_lvl;
    assign o_schmitt = HAS_SCHMITT;
    assign o_ttl = ~HAS_SCHMITT & ~i_lvl;
endmodule
`default_nettype wire

// ---- verification/ppc_asserts.sv ----
// Port checker; open-drain-only bits 3:2 as in default masks.
`timescale 1ns/1ps
`default_nettype none
module ppc_asserts (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire [7:0] i_cfg_lvl,
    input wire [7:0] i_cfg_one,
    input wire [7:0] i_cfg_zero,
    input wire [7:0] i_gpio_out,
    input wire [7:0] o_pin_out,
    input wire [7:0] o_pin_oe,
    input wire [7:0] o_pullup,
    input wire [7:0] o_schmitt,
    input wire [7:0] o_ttl,
    input wire [7:0] o_ain_sel
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    property p_pu; (o_pullup & 8'h0c) == 8'h00; endproperty
    a_pu: assert property (p_pu) else $error("pullup");
    property p_od; (o_pin_out & o_pin_oe & 8'h0c) == 8'h00; endproperty
    a_od: assert property (p_od) else $error("od high");
    property p_st; $past(i_nrst) && $past(i_ce) |-> (o_schmitt & 8'hf3) == 8'hf3; endproperty
    a_st: assert property (p_st) else $error("schmitt");
    property p_tt; (o_ttl & 8'hf3) == 8'h00; endproperty
    a_tt: assert property (p_tt) else $error("ttl");
    property p_ns; (o_schmitt & 8'h0c) == 8'h00; endproperty
    a_ns: assert property (p_ns) else $error("no schmitt");
    property p_pp; i_ce && i_cfg_zero[0] && !i_cfg_one[0] && !i_cfg_lvl[0]
        |=> o_pin_oe[0] && o_pin_out[0] == $past(i_gpio_out[0]); endproperty
    a_pp: assert property (p_pp) else $error("output");
    property p_in; i_ce && !i_cfg_lvl[1] && !i_cfg_one[1] && !i_cfg_zero[1]
        |=> !o_pin_oe[1] && o_pullup[1]; endproperty
    a_in: assert property (p_in) else $error("input");
    property p_ad; $rose(o_ain_sel[0]) |-> $past(i_cfg_one[0] && !i_cfg_zero[0]); endproperty
    a_ad: assert property (p_ad) else $error("ain");
    property p_sa; i_ce && i_cfg_lvl[0] && !i_cfg_one[0] && i_cfg_zero[0]
        |=> !o_pin_oe[0]; endproperty
    a_sa: assert property (p_sa) else $error("function input drives");
    property p_odm; i_ce && i_cfg_lvl[0] && i_cfg_one[0] && !i_cfg_zero[0]
        |=> !o_pin_out[0] && o_pin_oe[0] == !$past(i_gpio_out[0]); endproperty
    a_odm: assert property (p_odm) else $error("open drain");
endmodule
bind ppc_port ppc_asserts chk (.*);
`default_nettype wire

// ---- verification/ppc_pins.sv ----
// Pins: port drive, else bench drive, else pull-up or a toggling level.
`timescale 1ns/1ps
`default_nettype none
module ppc_pins (
    input wire logic i_clk,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_pu,
    input wire logic [7:0] i_ext,
    input wire logic [7:0] i_een,
    output logic [7:0] o_pin
);
    logic [7:0] tog_r = 8'h00;
    always @(posedge i_clk) tog_r <= ~tog_r;
    assign o_pin = i_oe & i_out | ~i_oe & (i_een & i_ext | ~i_een & (i_pu | tog_r));
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Bench for ppc_port with default masks except MEM_MASK (8'h30) and the pin model.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic c = 0, r = 0, ce = 1, me = 0;
    logic [7:0] mo = 0, moe = 0;
    logic [7:0] l = 0, o = 0, z = 0, g = 0, pf = 8'hf0, ex = 8'h3c, en = 0, t0;
    wire [7:0] po, oe, pu, st, tt, ai, pi, fi, pin;
    int n_fail = 0, checks = 0;
    // Bits 5:4 stand in for memory-interface bits so the override is exercised
    ppc_port #(.MEM_MASK(8'h30)) dut (.i_sys_clk(c), .i_nrst(r), .i_ce(ce), .i_cfg_lvl(l),
        .i_cfg_one(o), .i_cfg_zero(z), .i_gpio_out(g), .i_pf_out(pf), .i_mem_en(me),
        .i_mem_out(mo), .i_mem_oe(moe), .i_pin(pin), .o_pin_out(po), .o_pin_oe(oe), .o_pullup(pu),
        .o_schmitt(st), .o_ttl(tt), .o_ain_sel(ai), .o_pin_in(pi), .o_pf_in(fi));
    ppc_pins pm (.i_clk(c), .i_oe(oe), .i_out(po), .i_pu(pu), .i_ext(ex), .i_een(en), .o_pin(pin));
    initial forever #12.5 c = ~c;
    task automatic k(string n, logic [7:0] e, logic [7:0] v);
        checks++;
        if (v !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", n, e, v);
        end
    endtask
    // Five edges covers the three-stage pin path
    task automatic s(logic [7:0] a, b, d, e);
        @(posedge c);
        #1 {l, o, z, g} = {a, b, d, e};
        repeat (5) @(posedge c);
        #1 $display("test done");
    endtask
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100us n_fail++;
        end_sim;
    end
    initial
    begin
        repeat (12) @(posedge c);
        k("rst", 8'h00, oe);
        #1 r = 1;
        s(0, 0, 8'hff, 8'ha5);
        k("hi", 8'ha1, po & oe);
        k("lo", 8'h5a, ~po & oe);
        s(0, 0, 0, 0);
        k("pu", 8'hf3, pu);
        k("pin", 8'hf3, fi & 8'hf3);
        t0 = tt;
        en = 8'hff;
        s(8'hff, 0, 0, 0);
        k("ext", 8'h3c, fi);
        k("pin_in", 8'h3c, pi);
        k("st", 8'hf3, st);
        k("ttl", 8'h0c, tt ^ t0);
        s(0, 8'hff, 0, 0);
        k("ain", 8'hff, ai);
        s(0, 0, 8'h0f, 0);
        k("mix", 8'h0f, oe);
        s(0, 8'hff, 8'hff, 0);
        k("af", 8'hf0, po & oe);
        ce = 0;
        s(0, 0, 0, 0);
        k("ce", 8'hf0, po & oe);
        ce = 1;
        s(8'hff, 0, 8'hff, 8'hff);
        k("afin", 8'h00, oe);
        s(8'hff, 8'hff, 0, 8'h0f);
        k("od", 8'hf0, oe);
        k("odhi", 8'h00, po);
        {me, mo, moe} = {1'b1, 8'h10, 8'h30};
        s(0, 0, 0, 0);
        k("mem_hi", 8'h10, po & oe);
        k("mem_lo", 8'h20, ~po & oe);
        end_sim;
    end
endmodule
`default_nettype wire
